// file: rtl/dcst_gap_timer.sv
// one down-counting gap timer: loaded on its triggering event, busy until zero
// assumes load and value come from logic on the same clock
`timescale 1ns/1ps
module dcst_gap_timer
  import dcst_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // load
  input wire logic load,
  input wire logic [dcst_pkg::CW-1:0] load_value,
  // status
  output logic busy
);
  typedef struct packed {
    logic [CW-1:0] cnt;
  } dcst_gap_st_t;

  dcst_gap_st_t st_reg;
  dcst_gap_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.cnt = load_value;
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = (st_reg.cnt != '0);
endmodule

// file: rtl/dcst_pkg.sv
// command-spacing timer package: command codes, states, timing counts, and cycle conversion functions
// assumes a single 50 MHz clock shared by the timer and the memory command path
//
// What this block does
// - two cycles after mode set before anything
// - self refresh exit: row cycle plus 10ns before non-read
// - self refresh exit: 200 cycles before read
// - precharge power-down exit: 2 cycles before non-read
// - fast active power-down exit: 2 cycles before read
// - slow active exit: 7-AL or 6-AL before read
// - clock runs setup+period+hold after enable drops
// - clock enable held three cycles each level
// - refresh every 7.8 us up to 85 C
// - refresh every 3.9 us above 85 C
// - mode bit 12 picks fast or slow exit
// - never more than eight refreshes owed
package dcst_pkg;
  localparam int CLK_PERIOD_PS = 20000;
  localparam int CW = 8;

  typedef enum logic [3:0] {
    DCST_NOP = 4'h0, DCST_MRS = 4'h1, DCST_DRIVE_MRS = 4'h2, DCST_READ = 4'h3,
    DCST_OTHER = 4'h4, DCST_REFRESH = 4'h5, DCST_SR_ENTER = 4'h6, DCST_SR_EXIT = 4'h7,
    DCST_PD_PRE_ENTER = 4'h8, DCST_PD_ACT_ENTER = 4'h9, DCST_PD_EXIT = 4'ha
  } dcst_cmd_t;

  typedef enum logic [3:0] {
    DCST_ACTIVE = 4'b0001, DCST_PD_PRE = 4'b0010, DCST_PD_ACT = 4'b0100,
    DCST_SELFREF = 4'b1000
  } dcst_state_t;

  // cycles for a least time given in ps, never under one
  function automatic int ceil_cyc(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // cycles for a longest time given in ns, never under one
  function automatic int floor_cyc_ns(input int ns);
    int c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // a gap of n cycles loads n-1 so the next command may go at cycle n
  function automatic logic [CW-1:0] gap_load(input int n);
    return (n > 0) ? CW'(n - 1) : '0;
  endfunction

  localparam int MODE_SET_GAP_CK = 2;
  localparam int CALIBRATION_OUTPUT_DELAY_PS = 12000;
  localparam int TERMINATION_OUTPUT_DELAY_PS = 12000;
  localparam int DRIVE_OUTPUT_DELAY_CK = ceil_cyc(CALIBRATION_OUTPUT_DELAY_PS > 
    TERMINATION_OUTPUT_DELAY_PS ? CALIBRATION_OUTPUT_DELAY_PS : TERMINATION_OUTPUT_DELAY_PS);
  localparam int REFRESH_ROW_CYCLE_PS = 197500;
  localparam int SELFREF_EXTRA_PS = 10000;
  localparam int SELFREF_EXIT_NONREAD_GAP_CK =
    ceil_cyc(REFRESH_ROW_CYCLE_PS + SELFREF_EXTRA_PS);
  localparam int SELFREF_EXIT_READ_GAP_CK = 200;
  localparam int PRECHARGE_PD_EXIT_GAP_CK = 2;
  localparam int ACTIVE_PD_FAST_EXIT_GAP_CK = 2;
  localparam int ACTIVE_PD_SLOW_BASE_FAST_GRADE = 7;
  localparam int ACTIVE_PD_SLOW_BASE_SLOW_GRADE = 6;
  localparam int INPUT_SETUP_PS = 200;
  localparam int INPUT_HOLD_PS = 275;
  localparam int CLOCK_HOLD_AFTER_ENABLE_DROP_CK =
    ceil_cyc(INPUT_SETUP_PS + CLK_PERIOD_PS + INPUT_HOLD_PS);
  localparam int ENABLE_MIN_PULSE_CK = 3;
  localparam int REFRESH_INTERVAL_NORMAL_NS = 7800;
  localparam int REFRESH_INTERVAL_HOT_NS = 3900;
  localparam int REFRESH_INTERVAL_NORMAL_CK = floor_cyc_ns(REFRESH_INTERVAL_NORMAL_NS);
  localparam int REFRESH_INTERVAL_HOT_CK = floor_cyc_ns(REFRESH_INTERVAL_HOT_NS);
  localparam int REFRESH_OWED_MAX = 8;
  localparam logic [3:0] OWED_RESET = 4'h0;
  localparam int REFI_W = 9;
  localparam int MODE_EXIT_BIT = 12;
endpackage

// file: rtl/dcst_spacing_timer.sv
// host-side command spacing and power-state timer for a double-data-rate memory
// assumes requests come from same-clock logic; the temperature flag is a pin
`timescale 1ns/1ps
module dcst_spacing_timer
  import dcst_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // configuration
  input wire logic [2:0] ADDITIVE_LATENCY,
  input wire logic SPEED_FAST,
  input wire logic TEMP_HIGH,
  // request
  input wire logic REQ_VALID,
  input wire dcst_pkg::dcst_cmd_t REQ_CMD,
  input wire logic REQ_A12,
  output logic REQ_READY,
  // memory side
  output logic MEM_CMD_VALID,
  output dcst_pkg::dcst_cmd_t MEM_CMD,
  output logic MEM_A12,
  output logic MEM_CKE,
  output logic MEM_CLK_RUN,
  // status
  output logic REQ_REJECT,
  output logic DRIVE_SETTLED,
  output logic REFRESH_DUE,
  output logic REFRESH_URGENT,
  output dcst_pkg::dcst_state_t POWER_STATE
);
  typedef struct packed {
    dcst_state_t state;
    logic cke;
    logic clk_run;
    logic cmd_valid;
    dcst_cmd_t cmd;
    logic a12;
    logic slow_exit;
    logic reject;
    logic temp_s1;
    logic temp_s2;
    logic [REFI_W-1:0] refi_cnt;
    logic [3:0] owed;
  } dcst_st_t;

  dcst_st_t st_reg;
  dcst_st_t st_next;

  // gap timers: mode set, non-read, read, clock enable, clock hold and drive output
  logic mrs_busy, nonread_busy, read_busy, cke_busy, hold_busy, drive_busy;
  logic ld_mrs, ld_nonread, ld_read, ld_cke, ld_hold, ld_drive;
  logic [CW-1:0] v_nonread, v_read;

  dcst_gap_timer u_mrs (.CLK(CLK), .SYS_RST(SYS_RST), .load(ld_mrs),
    .load_value(gap_load(MODE_SET_GAP_CK)), .busy(mrs_busy));
  dcst_gap_timer u_nonread (.CLK(CLK), .SYS_RST(SYS_RST), .load(ld_nonread),
    .load_value(v_nonread), .busy(nonread_busy));
  dcst_gap_timer u_read (.CLK(CLK), .SYS_RST(SYS_RST), .load(ld_read),
    .load_value(v_read), .busy(read_busy));
  dcst_gap_timer u_cke (.CLK(CLK), .SYS_RST(SYS_RST), .load(ld_cke),
    .load_value(gap_load(ENABLE_MIN_PULSE_CK)), .busy(cke_busy));
  dcst_gap_timer u_hold (.CLK(CLK), .SYS_RST(SYS_RST), .load(ld_hold),
    .load_value(gap_load(CLOCK_HOLD_AFTER_ENABLE_DROP_CK)), .busy(hold_busy));
  dcst_gap_timer u_drive (.CLK(CLK), .SYS_RST(SYS_RST), .load(ld_drive),
    .load_value(gap_load(DRIVE_OUTPUT_DELAY_CK)), .busy(drive_busy));

  // slow active exit read gap, clamped at zero
  logic [3:0] slow_base;
  logic [3:0] slow_gap;
  always_comb begin
    slow_base = SPEED_FAST ? 4'(ACTIVE_PD_SLOW_BASE_FAST_GRADE)
                           : 4'(ACTIVE_PD_SLOW_BASE_SLOW_GRADE);
    slow_gap = (slow_base > {1'b0, ADDITIVE_LATENCY}) ?
               (slow_base - {1'b0, ADDITIVE_LATENCY}) : 4'h0;
  end

  // acceptance
  logic is_exit, is_enter, is_read, is_nonread, legal, clear, accept, urgent;
  always_comb begin
    is_exit = (REQ_CMD == DCST_SR_EXIT) || (REQ_CMD == DCST_PD_EXIT);
    is_enter = (REQ_CMD == DCST_SR_ENTER) || (REQ_CMD == DCST_PD_PRE_ENTER) ||
               (REQ_CMD == DCST_PD_ACT_ENTER);
    is_read = (REQ_CMD == DCST_READ);
    is_nonread = !is_read && !is_exit && (REQ_CMD != DCST_NOP);
    urgent = (st_reg.owed == 4'(REFRESH_OWED_MAX));
    case (st_reg.state)
      DCST_ACTIVE: legal = !is_exit;
      DCST_SELFREF: legal = (REQ_CMD == DCST_SR_EXIT);
      DCST_PD_PRE, DCST_PD_ACT: legal = (REQ_CMD == DCST_PD_EXIT);
      default: legal = 1'b0;
    endcase
    clear = !mrs_busy;
    if (is_read && read_busy) begin
      clear = 1'b0;
    end
    if (is_nonread && nonread_busy) begin
      clear = 1'b0;
    end
    if ((is_enter || is_exit) && cke_busy) begin
      clear = 1'b0;
    end
    if (urgent && legal && st_reg.state == DCST_ACTIVE && REQ_CMD != DCST_REFRESH) begin
      clear = 1'b0;
    end
    REQ_READY = !legal || clear;
    accept = REQ_VALID && legal && clear;
  end

  always_comb begin
    st_next = st_reg;
    st_next.cmd_valid = 1'b0;
    st_next.reject = REQ_VALID && !legal;
    st_next.temp_s1 = TEMP_HIGH;
    st_next.temp_s2 = st_reg.temp_s1;
    ld_mrs = 1'b0;
    ld_nonread = 1'b0;
    ld_read = 1'b0;
    ld_cke = 1'b0;
    ld_hold = 1'b0;
    ld_drive = 1'b0;
    v_nonread = '0;
    v_read = '0;
    // refresh interval tick by temperature range
    if (st_reg.state == DCST_SELFREF) begin
      st_next.refi_cnt = '0;
    end else if ((st_reg.temp_s2 && st_reg.refi_cnt >= REFI_W'(REFRESH_INTERVAL_HOT_CK - 1)) ||
                 st_reg.refi_cnt >= REFI_W'(REFRESH_INTERVAL_NORMAL_CK - 1)) begin
      st_next.refi_cnt = '0;
      if (!urgent) begin
        st_next.owed = st_reg.owed + 1'b1;
      end
    end else begin
      st_next.refi_cnt = st_reg.refi_cnt + 1'b1;
    end
    // in self refresh only, the clock stops once the hold after the enable drop has run out
    if (st_reg.state == DCST_SELFREF && !st_reg.cke && !hold_busy && !ld_hold) begin
      st_next.clk_run = 1'b0;
    end
    if (accept && REQ_CMD != DCST_NOP) begin
      st_next.cmd_valid = 1'b1;
      st_next.cmd = REQ_CMD;
      st_next.a12 = REQ_A12;
      case (REQ_CMD)
        DCST_MRS: begin
          ld_mrs = 1'b1;
          st_next.slow_exit = REQ_A12;
        end
        DCST_DRIVE_MRS: begin
          ld_mrs = 1'b1;
          ld_drive = 1'b1;
        end
        DCST_REFRESH: begin
          if (st_reg.owed != OWED_RESET && !(st_next.owed != st_reg.owed)) begin
            st_next.owed = st_reg.owed - 1'b1;
          end else if (st_next.owed != st_reg.owed) begin
            st_next.owed = st_reg.owed;
          end
        end
        DCST_SR_ENTER: begin
          st_next.state = DCST_SELFREF;
          st_next.cke = 1'b0;
          st_next.owed = OWED_RESET;
          ld_cke = 1'b1;
          ld_hold = 1'b1;
        end
        DCST_PD_PRE_ENTER: begin
          st_next.state = DCST_PD_PRE;
          st_next.cke = 1'b0;
          ld_cke = 1'b1;
        end
        DCST_PD_ACT_ENTER: begin
          st_next.state = DCST_PD_ACT;
          st_next.cke = 1'b0;
          ld_cke = 1'b1;
        end
        DCST_SR_EXIT: begin
          st_next.state = DCST_ACTIVE;
          st_next.cke = 1'b1;
          st_next.clk_run = 1'b1;
          ld_cke = 1'b1;
          ld_nonread = 1'b1;
          v_nonread = gap_load(SELFREF_EXIT_NONREAD_GAP_CK);
          ld_read = 1'b1;
          v_read = gap_load(SELFREF_EXIT_READ_GAP_CK);
        end
        DCST_PD_EXIT: begin
          st_next.state = DCST_ACTIVE;
          st_next.cke = 1'b1;
          ld_cke = 1'b1;
          if (st_reg.state == DCST_PD_PRE) begin
            ld_nonread = 1'b1;
            v_nonread = gap_load(PRECHARGE_PD_EXIT_GAP_CK);
          end else if (st_reg.slow_exit) begin
            ld_read = 1'b1;
            v_read = gap_load(int'(slow_gap));
          end else begin
            ld_read = 1'b1;
            v_read = gap_load(ACTIVE_PD_FAST_EXIT_GAP_CK);
          end
        end
        default: begin
          st_next.cmd = REQ_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_reg <= '{state: DCST_ACTIVE, cke: 1'b1, clk_run: 1'b1, cmd_valid: 1'b0,
                  cmd: DCST_NOP, a12: 1'b0, slow_exit: 1'b0, reject: 1'b0,
                  temp_s1: 1'b0, temp_s2: 1'b0, refi_cnt: '0, owed: OWED_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign MEM_CMD_VALID = st_reg.cmd_valid;
  assign MEM_CMD = st_reg.cmd;
  assign MEM_A12 = st_reg.a12;
  assign MEM_CKE = st_reg.cke;
  assign MEM_CLK_RUN = st_reg.clk_run;
  assign REQ_REJECT = st_reg.reject;
  assign DRIVE_SETTLED = !drive_busy;
  assign REFRESH_DUE = (st_reg.owed != OWED_RESET);
  assign REFRESH_URGENT = (st_reg.owed == 4'(REFRESH_OWED_MAX));
  assign POWER_STATE = st_reg.state;
endmodule

// file: verification/dcst_mem_model.sv
// memory-side model: latches exit mode, shows drive output, counts mode-set gap faults
// assumes one-cycle command pulses on the shared clock
`timescale 1ns/1ps
module dcst_mem_model
  import dcst_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // command
  input wire logic MEM_CMD_VALID,
  input wire dcst_pkg::dcst_cmd_t MEM_CMD,
  input wire logic MEM_A12,
  // observation
  output logic slow_exit,
  output logic drive_out,
  output logic [7:0] gap_err
);
  logic mode_last;
  logic drive_reg;
  wire logic mode_now = MEM_CMD_VALID && (MEM_CMD == DCST_MRS || MEM_CMD == DCST_DRIVE_MRS);
  // output appears with the command itself, well inside the bound
  assign drive_out = drive_reg || (MEM_CMD_VALID && MEM_CMD == DCST_DRIVE_MRS);
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      slow_exit <= 1'b0;
      drive_reg <= 1'b0;
      mode_last <= 1'b0;
      gap_err <= 8'h0;
    end else begin
      mode_last <= mode_now;
      if (MEM_CMD_VALID && mode_last) gap_err <= gap_err + 8'h1;
      if (mode_now) drive_reg <= MEM_CMD == DCST_DRIVE_MRS;
      if (MEM_CMD_VALID && MEM_CMD == DCST_MRS) slow_exit <= MEM_A12;
    end
  end
endmodule

// file: verification/dcst_spacing_sva.sv
// checker: spacing, clock-enable and refresh relations at the timer's ports
// assumes bind onto dcst_spacing_timer, one clock domain
`timescale 1ns/1ps
module dcst_spacing_sva
  import dcst_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic REQ_VALID,
  input wire dcst_pkg::dcst_cmd_t REQ_CMD,
  input wire logic REQ_READY,
  input wire logic MEM_CMD_VALID,
  input wire dcst_pkg::dcst_cmd_t MEM_CMD,
  input wire logic MEM_CKE,
  input wire logic MEM_CLK_RUN,
  input wire logic REFRESH_DUE,
  input wire logic REFRESH_URGENT,
  input wire dcst_pkg::dcst_state_t POWER_STATE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_iss(dcst_cmd_t c);
    MEM_CMD_VALID && MEM_CMD == c;
  endsequence
  sequence s_nonrd;
    MEM_CMD_VALID && MEM_CMD != DCST_READ;
  endsequence
  AST_MRS_GAP: assert property (s_iss(DCST_MRS) |=> !MEM_CMD_VALID)
    else $error("command right after mode set");
  AST_SR_NONREAD: assert property (s_iss(DCST_SR_EXIT) |-> not (##[1:10] s_nonrd))
    else $error("non-read too soon after self refresh exit");
  AST_SR_READ: assert property (s_iss(DCST_SR_EXIT) |-> not (##[1:199] s_iss(DCST_READ)))
    else $error("read too soon after self refresh exit");
  AST_CKE_PULSE: assert property ($changed(MEM_CKE) |=> $stable(MEM_CKE)[*2])
    else $error("clock enable pulse too short");
  AST_CLK_HOLD: assert property ($fell(MEM_CKE) |-> MEM_CLK_RUN[*2])
    else $error("clock stopped too soon after enable drop");
  AST_ACCEPT: assert property (REQ_VALID && REQ_READY && REQ_CMD == DCST_READ &&
    POWER_STATE == DCST_ACTIVE |=> s_iss(DCST_READ)) else $error("read not issued");
  AST_URGENT: assert property (REFRESH_URGENT && REQ_VALID && REQ_CMD == DCST_OTHER
    && POWER_STATE == DCST_ACTIVE |-> !REQ_READY)
    else $error("command taken with eight refreshes owed");
  AST_REFI: assert property ($fell(REFRESH_DUE) && POWER_STATE == DCST_ACTIVE
    |-> ##[1:392] (REFRESH_DUE || POWER_STATE != DCST_ACTIVE))
    else $error("refresh tick missing");
endmodule
bind dcst_spacing_timer dcst_spacing_sva chk_u (.*);

// file: verification/tb_top.sv
// testbench: drives the spacing timer beside a memory model and checks gaps
// assumes the design package and the model are compiled first
`timescale 1ns/1ps
module tb_top;
  import dcst_pkg::*;
  logic CLK = 0, SYS_RST = 1, SPEED_FAST = 0, TEMP_HIGH = 0, REQ_VALID = 0, REQ_A12 = 0;
  logic [2:0] ADDITIVE_LATENCY = 3'h2;
  dcst_cmd_t REQ_CMD = DCST_NOP, MEM_CMD;
  dcst_state_t POWER_STATE;
  logic REQ_READY, MEM_CMD_VALID, MEM_A12, MEM_CKE, MEM_CLK_RUN, REQ_REJECT, DRIVE_SETTLED;
  logic REFRESH_DUE, REFRESH_URGENT, slow_exit, drive_out;
  logic [7:0] gap_err;
  int errors = 0, total_checks = 0, n, m;
  initial forever #10 CLK = ~CLK;
  dcst_spacing_timer dut_u (.*);
  dcst_mem_model mem_u (.*);
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // starts on a rising edge, returns on the rising edge after the take
  task automatic issue(input dcst_cmd_t c, input logic a, input logic ok, output int w);
    REQ_VALID <= 1'b1;
    REQ_CMD <= c;
    REQ_A12 <= a;
    w = 0;
    @(negedge CLK);
    while (REQ_READY !== 1'b1) begin
      @(negedge CLK);
      w++;
      if (w > 400) begin
        cmp("ready timeout", 0, 1);
        summarize();
      end
    end
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    @(negedge CLK);
    cmp("issue", {ok, ~ok, c}, {MEM_CMD_VALID, REQ_REJECT, ok ? MEM_CMD : c});
    @(posedge CLK);
  endtask
  task automatic wt(input logic u, output int w);
    w = 0;
    @(negedge CLK);
    while ((u ? REFRESH_URGENT : REFRESH_DUE) !== 1'b1) begin
      @(negedge CLK);
      w++;
      if (w > 4000) begin
        cmp("refresh timeout", 0, 1);
        summarize();
      end
    end
    @(posedge CLK);
  endtask
  task automatic drain;
    @(negedge CLK);
    while (REFRESH_DUE === 1'b1) begin
      @(posedge CLK);
      issue(DCST_REFRESH, 1'b0, 1'b1, n);
      @(negedge CLK);
    end
    @(posedge CLK);
  endtask
  task automatic interval(input int e);
    drain();
    wt(1'b0, m);
    drain();
    wt(1'b0, m);
    cmp("interval", 1, m >= e - 10 && m <= e);
  endtask
  task automatic t_mrs;
    issue(DCST_MRS, 1'b1, 1'b1, n);
    // bit 12 set on the following command too, so the carried bit is seen high
    issue(DCST_OTHER, 1'b1, 1'b1, n);
    cmp("mode gap", MODE_SET_GAP_CK, n + 2);
    cmp("exit mode", 2'b11, {MEM_A12, slow_exit});
    issue(DCST_DRIVE_MRS, 1'b0, 1'b1, n);
    @(negedge CLK);
    cmp("drive", 2'b11, {drive_out, DRIVE_SETTLED});
    @(posedge CLK);
  endtask
  task automatic t_sr;
    issue(DCST_SR_ENTER, 1'b0, 1'b1, n);
    @(negedge CLK);
    cmp("sr run", {DCST_SELFREF, 2'b01}, {POWER_STATE, MEM_CKE, MEM_CLK_RUN});
    @(negedge CLK);
    cmp("sr stop", 0, MEM_CLK_RUN);
    @(posedge CLK);
    issue(DCST_READ, 1'b0, 1'b0, n);
    issue(DCST_SR_EXIT, 1'b0, 1'b1, n);
    issue(DCST_OTHER, 1'b0, 1'b1, n);
    cmp("sr nonread", SELFREF_EXIT_NONREAD_GAP_CK, n + 2);
    issue(DCST_READ, 1'b0, 1'b1, m);
    cmp("sr read", SELFREF_EXIT_READ_GAP_CK, n + m + 4);
  endtask
  task automatic t_pd(input logic s, input dcst_cmd_t e, input logic a, input dcst_cmd_t c,
      input int g);
    SPEED_FAST <= s;
    issue(DCST_MRS, a, 1'b1, n);
    issue(e, 1'b0, 1'b1, n);
    issue(DCST_PD_EXIT, 1'b0, 1'b1, n);
    cmp("cke pulse", ENABLE_MIN_PULSE_CK, n + 2);
    issue(c, 1'b0, 1'b1, n);
    cmp("exit gap", g, n + 2);
  endtask
  task automatic t_ref;
    interval(REFRESH_INTERVAL_NORMAL_CK);
    TEMP_HIGH <= 1'b1;
    interval(REFRESH_INTERVAL_HOT_CK);
    wt(1'b1, n);
    REQ_VALID <= 1'b1;
    REQ_CMD <= DCST_OTHER;
    @(negedge CLK);
    cmp("urgent block", 0, REQ_READY);
    repeat (400) @(posedge CLK);
    issue(DCST_REFRESH, 1'b0, 1'b1, n);
    @(negedge CLK);
    cmp("owed seven", 2'b10, {REFRESH_DUE, REFRESH_URGENT});
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(negedge CLK);
    cmp("reset", {DCST_ACTIVE, 4'hd}, {POWER_STATE, MEM_CKE, MEM_CLK_RUN, REFRESH_DUE,
      DRIVE_SETTLED});
    @(posedge CLK);
    t_mrs();
    t_sr();
    t_pd(1'b0, DCST_PD_PRE_ENTER, 1'b0, DCST_OTHER, PRECHARGE_PD_EXIT_GAP_CK);
    t_pd(1'b0, DCST_PD_ACT_ENTER, 1'b0, DCST_READ, ACTIVE_PD_FAST_EXIT_GAP_CK);
    t_pd(1'b1, DCST_PD_ACT_ENTER, 1'b1, DCST_READ, ACTIVE_PD_SLOW_BASE_FAST_GRADE - 2);
    t_pd(1'b0, DCST_PD_ACT_ENTER, 1'b1, DCST_READ, ACTIVE_PD_SLOW_BASE_SLOW_GRADE - 2);
    t_ref();
    cmp("model gap faults", 0, gap_err);
    summarize();
  end
endmodule
